// ### hw/lapv5_frame_decoder.sv
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/10ps
module lapv5_frame_decoder import lapv5_pkg::*; (
    // system
    input wire logic clk_sys,
    input wire logic reset_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // monitored line
    input wire logic line_clk,
    input wire logic line_data,
    // information octet stream
    output logic info_valid,
    output logic [7:0] info_data,
    output logic [1:0] info_seg,
    // frame result
    output logic frame_done,
    output logic [1:0] frame_status,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // line sampling and bit destuffing

    logic lclk_s1_q, lclk_s2_q, lclk_s3_q, ldat_s1_q, ldat_s2_q;
    logic [2:0] ones_d, ones_q, bcnt_d, bcnt_q;
    logic [7:0] byte_d, byte_q, octet_v;
    logic bit_en, ev_flag, ev_abort, ev_octet;

    assign bit_en = lclk_s2_q & ~lclk_s3_q;

    always_comb begin
        ones_d = ones_q;
        byte_d = byte_q;
        bcnt_d = bcnt_q;
        ev_flag = 1'b0;
        ev_abort = 1'b0;
        ev_octet = 1'b0;
        octet_v = {ldat_s2_q, byte_q[7:1]};
        if (bit_en) begin
            if (ldat_s2_q) begin
                if (ones_q != ONES_ABORT) begin
                    ones_d = ones_q + 3'h1;
                end
                if (ones_q == ONES_FLAG) begin
                    ev_abort = 1'b1;
                end else if (ones_q < ONES_STUFF) begin
                    byte_d = octet_v;
                    bcnt_d = bcnt_q + 3'h1;
                    ev_octet = (bcnt_q == 3'h7);
                end
            end else begin
                ones_d = 3'h0;
                if (ones_q == ONES_FLAG) begin
                    ev_flag = 1'b1;
                    bcnt_d = 3'h0;
                end else if (ones_q != ONES_STUFF) begin
                    byte_d = octet_v;
                    bcnt_d = bcnt_q + 3'h1;
                    ev_octet = (bcnt_q == 3'h7);
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lclk_s1_q <= 1'b0;
            lclk_s2_q <= 1'b0;
            lclk_s3_q <= 1'b0;
            ldat_s1_q <= 1'b0;
            ldat_s2_q <= 1'b0;
            ones_q <= 3'h0;
            bcnt_q <= 3'h0;
            byte_q <= 8'h00;
        end else begin
            lclk_s1_q <= line_clk;
            lclk_s2_q <= lclk_s1_q;
            lclk_s3_q <= lclk_s2_q;
            ldat_s1_q <= line_data;
            ldat_s2_q <= ldat_s1_q;
            ones_q <= ones_d;
            bcnt_q <= bcnt_d;
            byte_q <= byte_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // frame assembly

    rx_state_t st_d, st_q;
    logic [11:0] cnt_d, cnt_q, len_d, len_q;
    logic [7:0] hold0_d, hold0_q, hold1_d, hold1_q;
    logic [15:0] addr_d, addr_q, res_addr_d, res_addr_q;
    logic [7:0] c4_d, c4_q, c5_d, c5_q, res_c4_d, res_c4_q, res_c5_d, res_c5_q;
    logic info_valid_d, info_valid_q, frame_done_d, frame_done_q;
    logic [7:0] info_data_d, info_data_q;
    seg_t info_seg_d, info_seg_q;
    frame_status_t fstat_d, fstat_q;
    logic [3:0] evt;
    logic [15:0] crc;
    logic aligned;
    logic [1:0] ctrl_q;
    logic [23:0] seg_q;

    lapv5_fcs u_fcs (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .restart(ev_flag),
        .octet_valid(ev_octet && st_q == RX_FRAME),
        .octet(octet_v),
        .crc(crc)
    );

    function automatic seg_t seg_of(input logic [11:0] idx, input logic [23:0] s,
                                    input logic ccs);
        logic [11:0] b0, b1, b2;
        b0 = {4'h0, s[7:0]};
        b1 = b0 + {4'h0, s[15:8]};
        b2 = b1 + {4'h0, s[23:16]};
        if (!ccs || idx < b0) begin
            return SEG_HEAD;
        end else if (idx < b1) begin
            return SEG_FIXED;
        end else if (idx < b2) begin
            return SEG_VAR;
        end
        return SEG_OPT;
    endfunction : seg_of

    assign aligned = (bcnt_q == FLAG_TAIL_BITS);

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        hold0_d = hold0_q;
        hold1_d = hold1_q;
        addr_d = addr_q;
        c4_d = c4_q;
        c5_d = c5_q;
        len_d = len_q;
        res_addr_d = res_addr_q;
        res_c4_d = res_c4_q;
        res_c5_d = res_c5_q;
        info_valid_d = 1'b0;
        info_data_d = info_data_q;
        info_seg_d = info_seg_q;
        frame_done_d = 1'b0;
        fstat_d = fstat_q;
        case (st_q)
            RX_HUNT: begin
                if (ev_flag && ctrl_q[CTRL_ENABLE_BIT]) begin
                    st_d = RX_FRAME;
                    cnt_d = 12'h000;
                end
            end
            RX_FRAME: begin
                if (ev_abort) begin
                    st_d = RX_HUNT;
                    if (cnt_q != 12'h000) begin
                        frame_done_d = 1'b1;
                        fstat_d = FS_ABORT;
                    end
                end else if (ev_flag) begin
                    cnt_d = 12'h000;
                    if (!ctrl_q[CTRL_ENABLE_BIT]) begin
                        st_d = RX_HUNT;
                    end
                    if (cnt_q != 12'h000 || !aligned) begin
                        frame_done_d = 1'b1;
                        if (!aligned || cnt_q < MIN_OCTETS) begin
                            fstat_d = FS_LENGTH;
                        end else if (crc == CRC_GOOD) begin
                            fstat_d = FS_GOOD;
                        end else begin
                            fstat_d = FS_CRC;
                        end
                    end
                end else if (ev_octet) begin
                    if (cnt_q == MAX_OCTETS) begin
                        st_d = RX_DISCARD;
                        frame_done_d = 1'b1;
                        fstat_d = FS_LENGTH;
                    end else begin
                        cnt_d = cnt_q + 12'h001;
                        hold0_d = octet_v;
                        hold1_d = hold0_q;
                        if (cnt_q == IDX_ADDR_HI) begin
                            addr_d[15:8] = octet_v;
                        end else if (cnt_q == IDX_ADDR_LO) begin
                            addr_d[7:0] = octet_v;
                        end else if (cnt_q == IDX_CTL_A) begin
                            c4_d = octet_v;
                        end else if (cnt_q == IDX_CTL_B) begin
                            c5_d = octet_v;
                        end
                        if (cnt_q >= INFO_FIRST) begin
                            // two octets held back so the fcs never reaches the stream
                            info_valid_d = 1'b1;
                            info_data_d = hold1_q;
                            info_seg_d = seg_of(cnt_q - INFO_FIRST, seg_q,
                                                ctrl_q[CTRL_CCS_BIT]);
                        end
                    end
                end
            end
            RX_DISCARD: begin
                if (ev_flag) begin
                    st_d = ctrl_q[CTRL_ENABLE_BIT] ? RX_FRAME : RX_HUNT;
                    cnt_d = 12'h000;
                end
            end
            default: begin
                st_d = RX_HUNT;
            end
        endcase
        if (frame_done_d) begin
            len_d = cnt_q;
            res_addr_d = addr_q;
            res_c4_d = c4_q;
            res_c5_d = c5_q;
        end
    end

    always_comb begin
        evt = 4'h0;
        if (frame_done_d) begin
            evt[fstat_d] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= RX_HUNT;
            cnt_q <= 12'h000;
            hold0_q <= 8'h00;
            hold1_q <= 8'h00;
            addr_q <= 16'h0000;
            c4_q <= 8'h00;
            c5_q <= 8'h00;
            len_q <= 12'h000;
            res_addr_q <= 16'h0000;
            res_c4_q <= 8'h00;
            res_c5_q <= 8'h00;
            info_valid_q <= 1'b0;
            info_data_q <= 8'h00;
            info_seg_q <= SEG_HEAD;
            frame_done_q <= 1'b0;
            fstat_q <= FS_GOOD;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            hold0_q <= hold0_d;
            hold1_q <= hold1_d;
            addr_q <= addr_d;
            c4_q <= c4_d;
            c5_q <= c5_d;
            len_q <= len_d;
            res_addr_q <= res_addr_d;
            res_c4_q <= res_c4_d;
            res_c5_q <= res_c5_d;
            info_valid_q <= info_valid_d;
            info_data_q <= info_data_d;
            info_seg_q <= info_seg_d;
            frame_done_q <= frame_done_d;
            fstat_q <= fstat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control field decode

    function automatic logic [24:0] ctl_decode(input logic [7:0] a, input logic [7:0] b);
        ctl_format_t f;
        logic pf;
        f = !a[0] ? FMT_I : (!a[1] ? FMT_S : FMT_U);
        pf = (f == FMT_U) ? a[4] : b[0];
        // fields: reserved-nonzero, modifier, p/f, n(r), n(s), s bits, format
        return {(f == FMT_S) && (a[7:4] != 4'h0),
                a[7:5], a[3:2], pf,
                b[7:1],
                a[7:1],
                a[3:2],
                f};
    endfunction : ctl_decode

    ////////////////////////////////////////////////////////////////////////////////
    // register bus and interrupt

    logic ap_wr_d, ap_wr_q;
    logic [11:0] ap_addr_d, ap_addr_q;
    logic [1:0] ctrl_d;
    logic [23:0] seg_d;
    logic [3:0] irq_en_d, irq_en_q, irq_st_d, irq_st_q, clr;
    logic [31:0] hrdata_d, hrdata_q;
    logic irq_d, irq_q;

    always_comb begin
        ap_wr_d = hsel && htrans[1] && hready && hwrite;
        ap_addr_d = ap_wr_d ? haddr[11:0] : ap_addr_q;
        ctrl_d = ctrl_q;
        seg_d = seg_q;
        irq_en_d = irq_en_q;
        clr = 4'h0;
        if (ap_wr_q) begin
            if (ap_addr_q == A_CTRL) begin
                ctrl_d = hwdata[1:0];
            end else if (ap_addr_q == A_SEG) begin
                seg_d = hwdata[23:0];
            end else if (ap_addr_q == A_IRQ_EN) begin
                irq_en_d = hwdata[3:0];
            end else if (ap_addr_q == A_IRQ_CLR) begin
                clr = hwdata[3:0];
            end
        end
        // a new event wins over a clear in the same cycle
        irq_st_d = (irq_st_q & ~clr) | evt;
        irq_d = |(irq_st_d & irq_en_d);
        hrdata_d = hrdata_q;
        if (hsel && htrans[1] && hready && !hwrite) begin
            hrdata_d = 32'h0000_0000;
            if (haddr[11:0] == A_CTRL) begin
                hrdata_d[1:0] = ctrl_d;
            end else if (haddr[11:0] == A_SEG) begin
                hrdata_d[23:0] = seg_d;
            end else if (haddr[11:0] == A_FRAME) begin
                hrdata_d = {4'h0, len_d, 14'h0000, fstat_d};
            end else if (haddr[11:0] == A_ADDR) begin
                hrdata_d[15:0] = res_addr_d;
            end else if (haddr[11:0] == A_CTL) begin
                hrdata_d[24:0] = ctl_decode(res_c4_d, res_c5_d);
            end else if (haddr[11:0] == A_IRQ_STAT) begin
                hrdata_d[3:0] = irq_st_d;
            end else if (haddr[11:0] == A_IRQ_EN) begin
                hrdata_d[3:0] = irq_en_d;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ap_wr_q <= 1'b0;
            ap_addr_q <= 12'h000;
            ctrl_q <= CTRL_RST;
            seg_q <= SEG_RST;
            irq_en_q <= IRQ_EN_RST;
            irq_st_q <= 4'h0;
            hrdata_q <= 32'h0000_0000;
            irq_q <= 1'b0;
        end else begin
            ap_wr_q <= ap_wr_d;
            ap_addr_q <= ap_addr_d;
            ctrl_q <= ctrl_d;
            seg_q <= seg_d;
            irq_en_q <= irq_en_d;
            irq_st_q <= irq_st_d;
            hrdata_q <= hrdata_d;
            irq_q <= irq_d;
        end
    end

    // zero wait states, always okay
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    assign hrdata = hrdata_q;
    assign info_valid = info_valid_q;
    assign info_data = info_data_q;
    assign info_seg = info_seg_q;
    assign frame_done = frame_done_q;
    assign frame_status = fstat_q;
    assign irq = irq_q;

endmodule : lapv5_frame_decoder

// ### hw/lapv5_pkg.sv
package lapv5_pkg;

    // line coding
    localparam logic [7:0] FLAG_OCTET = 8'h7e;
    localparam logic [2:0] ONES_STUFF = 3'h5;
    localparam logic [2:0] ONES_FLAG = 3'h6;
    localparam logic [2:0] ONES_ABORT = 3'h7;
    localparam logic [2:0] FLAG_TAIL_BITS = 3'h6;

    // frame check sequence
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_GOOD = 16'hf0b8;

    // frame length limits in octets between flags
    localparam logic [11:0] MIN_OCTETS = 12'h005;
    localparam logic [11:0] MAX_OCTETS = 12'h104;
    localparam logic [11:0] INFO_FIRST = 12'h004;

    // octet positions after the opening flag
    localparam logic [11:0] IDX_ADDR_HI = 12'h000;
    localparam logic [11:0] IDX_ADDR_LO = 12'h001;
    localparam logic [11:0] IDX_CTL_A = 12'h002;
    localparam logic [11:0] IDX_CTL_B = 12'h003;

    // register byte addresses
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_SEG = 12'h004;
    localparam logic [11:0] A_FRAME = 12'h008;
    localparam logic [11:0] A_ADDR = 12'h00c;
    localparam logic [11:0] A_CTL = 12'h010;
    localparam logic [11:0] A_IRQ_STAT = 12'h014;
    localparam logic [11:0] A_IRQ_CLR = 12'h018;
    localparam logic [11:0] A_IRQ_EN = 12'h01c;

    // control register fields and reset values
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CCS_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam logic [23:0] SEG_RST = 24'h00_0000;
    localparam logic [3:0] IRQ_EN_RST = 4'h0;

    typedef enum logic [1:0] {
        FS_GOOD = 2'h0, FS_CRC = 2'h1, FS_ABORT = 2'h2, FS_LENGTH = 2'h3
    } frame_status_t;
    typedef enum logic [1:0] {
        FMT_I = 2'h0, FMT_S = 2'h1, FMT_U = 2'h2
    } ctl_format_t;
    typedef enum logic [1:0] {
        SEG_HEAD = 2'h0, SEG_FIXED = 2'h1, SEG_VAR = 2'h2, SEG_OPT = 2'h3
    } seg_t;
    typedef enum logic [2:0] {
        RX_HUNT = 3'b001, RX_FRAME = 3'b010, RX_DISCARD = 3'b100
    } rx_state_t;

endpackage : lapv5_pkg

// ### hw/lapv5_fcs.sv
`timescale 1ns/10ps
module lapv5_fcs import lapv5_pkg::*; (
    // system
    input wire logic clk_sys,
    input wire logic reset_n,
    // octet feed
    input wire logic restart,
    input wire logic octet_valid,
    input wire logic [7:0] octet,
    // running remainder
    output logic [15:0] crc
);

    logic [15:0] crc_d;
    logic [15:0] crc_q;

    function automatic logic [15:0] fcs_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : fcs_step

    always_comb begin
        crc_d = crc_q;
        if (restart) begin
            crc_d = CRC_INIT;
        end else if (octet_valid) begin
            crc_d = fcs_step(crc_q, octet);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            crc_q <= CRC_INIT;
        end else begin
            crc_q <= crc_d;
        end
    end

    assign crc = crc_q;

endmodule : lapv5_fcs

// ### verification/lapv5_frame_decoder_checker.sv
`timescale 1ns/10ps
module lapv5_frame_decoder_checker import lapv5_pkg::*; (
    // system
    input wire logic clk_sys,
    input wire logic reset_n,
    // ahb-lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // results
    input wire logic info_valid,
    input wire logic [7:0] info_data,
    input wire logic [1:0] info_seg,
    input wire logic frame_done,
    input wire logic [1:0] frame_status,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // an octet takes at least 48 system clocks from the line model
    sequence s_info_quiet; !info_valid [*8]; endsequence
    sequence s_done_quiet; !frame_done [*8]; endsequence
    property p_info_gap; info_valid |=> s_info_quiet; endproperty
    a_info_gap: assert property (p_info_gap)
        else $error("info pulse repeats too soon");
    property p_done_gap; frame_done |=> s_done_quiet; endproperty
    a_done_gap: assert property (p_done_gap)
        else $error("frame done repeats too soon");
    property p_status_hold; !frame_done |-> $stable(frame_status); endproperty
    a_status_hold: assert property (p_status_hold)
        else $error("status moved without frame done");
    property p_info_hold; !info_valid |-> $stable(info_data) && $stable(info_seg); endproperty
    a_info_hold: assert property (p_info_hold)
        else $error("info octet moved without pulse");
    property p_irq_cause;
        $rose(irq) |-> frame_done || $past(hsel && htrans[1] && hwrite, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq rose without a cause");
    property p_bus_okay; hreadyout && !hresp; endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus not ready or error response");
    property p_reset_out; $rose(reset_n) |-> !frame_done && !info_valid && !irq; endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs active right after reset");
    property p_unmapped;
        hsel && htrans[1] && hready && !hwrite && haddr[11:0] >= 12'h020
            |=> hrdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
endmodule : lapv5_frame_decoder_checker

// ### verification/lapv5_line_model.sv
`timescale 1ns/10ps
module lapv5_line_model import lapv5_pkg::*; (
    // system
    input wire logic clk_sys,
    // monitored line
    output logic line_clk,
    output logic line_data
);
    int ones = 0;
    initial begin
        line_clk = 1'b0;
        line_data = 1'b1;
    end
    // clock low three periods, high three periods
    task automatic send_bit(input logic b);
        @(posedge clk_sys);
        line_clk <= 1'b0;
        line_data <= b;
        repeat (3) @(posedge clk_sys);
        line_clk <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask : send_bit
    task automatic send_octet(input logic [7:0] v, input bit stuff);
        for (int i = 0; i < 8; i++) begin
            send_bit(v[i]);
            ones = (v[i] && stuff) ? ones + 1 : 0;
            if (ones == 5) begin
                send_bit(1'b0);
                ones = 0;
            end
        end
    endtask : send_octet
    function automatic logic [15:0] fcs_of(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[k]) for (int i = 0; i < 8; i++)
            c = (c[0] ^ q[k][i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
        return ~c;
    endfunction : fcs_of
    // mode 0 good, 1 corrupted first check octet, 2 abort after the octets
    task automatic send_frame(input logic [7:0] q[$], input int mode);
        logic [15:0] f;
        f = fcs_of(q) ^ ((mode == 1) ? 16'h0001 : 16'h0000);
        send_octet(FLAG_OCTET, 1'b0);
        foreach (q[k]) send_octet(q[k], 1'b1);
        if (mode == 2) begin
            repeat (7) send_bit(1'b1);
        end else begin
            send_octet(f[7:0], 1'b1);
            send_octet(f[15:8], 1'b1);
            send_octet(FLAG_OCTET, 1'b0);
        end
        ones = 0;
        @(posedge clk_sys);
        line_clk <= 1'b0;
        line_data <= ~line_data;
    endtask : send_frame
endmodule : lapv5_line_model

// ### verification/lapv5_frame_decoder_tb.sv
`timescale 1ns/10ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("FAIL %0t %s", $time, m); end end
module lapv5_frame_decoder_tb import lapv5_pkg::*; ();
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, line_clk, line_data, info_valid, frame_done, irq;
    logic [7:0] info_data;
    logic [1:0] info_seg, frame_status;
    int err_total = 0, check_count = 0, cycles = 0, done_cnt = 0;
    logic [7:0] exp_info[$];
    logic [1:0] exp_seg[$], exp_stat[$];
    logic [31:0] lfsr = 32'h4161_70ec;
    logic [31:0] msk[3] = '{32'h0007_fff3, 32'h0107_f80f, 32'h00fc_0003};
    always #50 clk_sys = ~clk_sys;
    lapv5_frame_decoder dut (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .line_clk(line_clk), .line_data(line_data), .info_valid(info_valid),
        .info_data(info_data), .info_seg(info_seg), .frame_done(frame_done),
        .frame_status(frame_status), .irq(irq));
    lapv5_line_model line (.clk_sys(clk_sys), .line_clk(line_clk), .line_data(line_data));
    ////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            complete_run();
        end
    end
    always @(posedge clk_sys) begin
        if (reset_n && info_valid) begin
            `CHK(info_data, (exp_info.size() > 0) ? exp_info.pop_front() : 8'hxx, "info")
            `CHK(info_seg, (exp_seg.size() > 0) ? exp_seg.pop_front() : 2'bxx, "seg")
        end
        if (reset_n && frame_done) begin
            `CHK(frame_status, (exp_stat.size() > 0) ? exp_stat.pop_front() : 2'bxx, "st")
            done_cnt++;
        end
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic [1:0] seg_of(input int r);
        return (r < 3) ? SEG_HEAD : (r < 5) ? SEG_FIXED : (r < 7) ? SEG_VAR : SEG_OPT;
    endfunction : seg_of
    function automatic logic [31:0] ctl_exp(input logic [7:0] c4, input logic [7:0] c5);
        logic [1:0] f;
        f = !c4[0] ? 2'h0 : c4[1] ? 2'h2 : 2'h1;
        return {7'h00, f == 2'h1 && c4[7:4] != 4'h0, c4[7:5], c4[3:2],
            (f == 2'h2) ? c4[4] : c5[0], c5[7:1], c4[7:1], c4[3:2], f};
    endfunction : ctl_exp
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        haddr <= {20'h0_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000);
        `CHK(rd & m, e & m, "register")
    endtask : rd_chk
    task automatic run_frame(input logic [7:0] q[$], input int mode, input logic [1:0] st);
        int n;
        int lim;
        n = done_cnt;
        // an overlong frame is cut at the limit, two octets of it still held back
        lim = (q.size() + 2 > int'(MAX_OCTETS)) ? int'(MAX_OCTETS) - 2
            : q.size() - ((mode == 2) ? 2 : 0);
        for (int k = 2; k < lim; k++) begin
            exp_info.push_back(q[k]);
            exp_seg.push_back(seg_of(k - 2));
        end
        exp_stat.push_back(st);
        line.send_frame(q, mode);
        while (done_cnt == n) @(posedge clk_sys);
        rd_chk(A_FRAME, (mode == 2) ? 32'h3 : 32'h0fff_0003,
            {4'h0, 12'((q.size() + 2 > int'(MAX_OCTETS)) ? int'(MAX_OCTETS) : q.size() + 2),
            14'h0, st});
        rd_chk(A_ADDR, 32'h0000_ffff, {16'h0000, q[0], q[1]});
    endtask : run_frame
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] q[$];
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd_chk(A_CTRL, 32'h0000_0003, {30'h0, CTRL_RST});
        rd_chk(A_SEG, 32'h00ff_ffff, {8'h00, SEG_RST});
        rd_chk(A_IRQ_EN, 32'h0000_000f, {28'h0, IRQ_EN_RST});
        ahb(1'b1, A_SEG, 32'h0002_0203);
        ahb(1'b1, A_CTRL, 32'h0000_0003);
        ahb(1'b1, A_IRQ_EN, 32'h0000_0001);
        rd_chk(A_SEG, 32'h00ff_ffff, 32'h0002_0203);
        rd_chk(12'h040, 32'hffff_ffff, 32'h0000_0000);
        for (int i = 0; i < 12; i++) begin
            q.delete();
            repeat (4 + i % 8) begin
                lfsr = lfsr_next(lfsr);
                q.push_back(lfsr[7:0]);
            end
            if (i % 3 == 0) q[2][0] = 1'b0;
            if (i % 3 == 1) q[2] = {(i == 10) ? 4'ha : 4'h0, 2'(i / 3), 2'b01};
            if (i % 3 == 2) q[2][1:0] = 2'b11;
            run_frame(q, 0, FS_GOOD);
            rd_chk(A_CTL, msk[i % 3], ctl_exp(q[2], q[3]));
        end
        `CHK(irq, 1'b1, "irq after good frame")
        q = q[0:5];
        run_frame(q, 1, FS_CRC);
        run_frame(q, 2, FS_ABORT);
        q = q[0:1];
        run_frame(q, 0, FS_LENGTH);
        q.delete();
        repeat (int'(MAX_OCTETS) - 1) begin
            lfsr = lfsr_next(lfsr);
            q.push_back(lfsr[7:0]);
        end
        run_frame(q, 0, FS_LENGTH);
        rd_chk(A_IRQ_STAT, 32'h0000_000f, 32'h0000_000f);
        ahb(1'b1, A_IRQ_CLR, 32'h0000_0001);
        repeat (3) @(posedge clk_sys);
        `CHK(irq, 1'b0, "irq masked after clear")
        rd_chk(A_IRQ_STAT, 32'h0000_000f, 32'h0000_000e);
        ahb(1'b1, A_IRQ_EN, 32'h0000_0004);
        repeat (3) @(posedge clk_sys);
        `CHK(irq, 1'b1, "irq on enable")
        ahb(1'b1, A_IRQ_CLR, 32'h0000_000f);
        repeat (3) @(posedge clk_sys);
        `CHK(irq, 1'b0, "irq after full clear")
        rd_chk(A_IRQ_STAT, 32'h0000_000f, 32'h0000_0000);
        complete_run();
    end
endmodule : lapv5_frame_decoder_tb
bind lapv5_frame_decoder lapv5_frame_decoder_checker chk (.clk_sys(clk_sys),
    .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .info_valid(info_valid), .info_data(info_data), .info_seg(info_seg),
    .frame_done(frame_done), .frame_status(frame_status), .irq(irq));
